/* File: pva_note_source.sv */
`timescale 1ns/1ps
module pva_note_source (
  input wire logic clock,
  input wire logic noteReady,
  input wire logic [pva_pkg::NUM_VOICES-1:0] voiceAttack,
  input wire logic [pva_pkg::NUM_VOICES-1:0] voiceEnvZero,
  output logic noteOnValid,
  output logic noteOffValid,
  output logic [pva_pkg::NOTE_W-1:0] noteNum
);
  import pva_pkg::*;
  logic [NUM_VOICES-1:0] attSeen;
  logic [NUM_VOICES-1:0] zeroSeen;
  logic hung;
  initial begin
    noteOnValid = 1'b0;
    noteOffValid = 1'b0;
    noteNum = 7'h00;
    hung = 1'b0;
  end
  // request held until an edge sees ready; the released note lines flip so a stale value cannot pass
  task automatic send(input logic on, input logic [NOTE_W-1:0] n, input int slow);
    int w;
    repeat (slow) @(posedge clock);
    noteOnValid <= on;
    noteOffValid <= !on;
    noteNum <= n;
    w = 0;
    do begin
      @(posedge clock);
      w++;
    end while (noteReady !== 1'b1 && w < 40);
    noteOnValid <= 1'b0;
    noteOffValid <= 1'b0;
    noteNum <= ~n;
    attSeen = '0;
    zeroSeen = '0;
    w = 0;
    do begin
      @(posedge clock);
      attSeen |= voiceAttack;
      zeroSeen |= voiceEnvZero;
      w++;
    end while (noteReady !== 1'b1 && w < 40);
    if (w >= 40) hung = 1'b1;
  endtask : send
endmodule : pva_note_source

/* File: pva_pkg.sv */
// Contract
// - Twelve independent voice slots, each sounding its own note at once.
// - Plain polyphonic mode gives one slot to each incoming note.
// - Stacked mode of size 2, 3, 4 or 6 takes next N free slots per note.
// - Twelve-voice stacked mode assigns all twelve slots to every note; the code does so only under last priority or with all slots free.
// - Single-voice monophonic mode always reuses the same one slot.
// - Mono group of size N plays fixed N slots, spread like stacked size N.
// - Limited polyphonic modes give one slot per note, capped at six or eight.
// - Even stack sizes leave no voice at root; odd sizes keep one there.
// - Detune amount, up to fifty cents, is spread across a note's voices.
// - Detune setting is 8 bits, 0..255 for zero..fifty cents, default 0.
// - Priority applies in mono modes or when notes exceed free slots.
// - Lowest priority: a lower new note steals the highest-note slot.
// - Highest priority: a higher new note steals the lowest-note slot.
// - Last priority, the default, steals the least recently played slot.
// - Default envelope policy starts attack from the current level.
// - Retrigger policy zeroes the envelope, then starts attack.
// - Legato policy does not restart a held envelope; attack after release.
// - One-shot zeroes envelope, starts attack, skips sustain after decay.
// - Pitch wander depth 0..255, default 0, slowly randomises both oscillators.
// - Setting wander depth 0..255 scales random offsets on ten voice settings.
// - Every voice owns separate random generators for pitch and setting wander.
// - Interval random in 1x..2x base; setting 0 is 25-50 ms, 255 is 2.5-5 s.
// - At interval end the value moves toward a new random target.
package pva_pkg;
  localparam int NUM_VOICES = 12;
  localparam int NOTE_W = 7;
  localparam int NUM_SETTINGS = 10;
  localparam int DRIFT_W = 8;
  localparam int AGE_W = 4;
  localparam logic [AGE_W-1:0] AGE_MAX = 4'hF;
  localparam logic [7:0] SPREAD_RESET = 8'h00;
  // allocation mode codes
  localparam logic [3:0] MODE_POLY = 4'h0;
  localparam logic [3:0] MODE_STACK2 = 4'h1;
  localparam logic [3:0] MODE_STACK3 = 4'h2;
  localparam logic [3:0] MODE_STACK4 = 4'h3;
  localparam logic [3:0] MODE_STACK6 = 4'h4;
  localparam logic [3:0] MODE_STACK12 = 4'h5;
  localparam logic [3:0] MODE_MONO = 4'h6;
  localparam logic [3:0] MODE_MONO2 = 4'h7;
  localparam logic [3:0] MODE_MONO3 = 4'h8;
  localparam logic [3:0] MODE_MONO4 = 4'h9;
  localparam logic [3:0] MODE_MONO6 = 4'hA;
  localparam logic [3:0] MODE_POLY6 = 4'hB;
  localparam logic [3:0] MODE_POLY8 = 4'hC;
  localparam logic [3:0] CAP_POLY6 = 4'h6;
  localparam logic [3:0] CAP_POLY8 = 4'h8;
  // note priority codes
  localparam logic [1:0] PRIO_LAST = 2'h0;
  localparam logic [1:0] PRIO_LOWEST = 2'h1;
  localparam logic [1:0] PRIO_HIGHEST = 2'h2;
  // envelope start policy codes
  localparam logic [1:0] ENV_FROM_LEVEL = 2'h0;
  localparam logic [1:0] ENV_RETRIGGER = 2'h1;
  localparam logic [1:0] ENV_LEGATO = 2'h2;
  localparam logic [1:0] ENV_ONE_SHOT = 2'h3;
  // wander timing
  localparam int CLK_KHZ = 250000;
  localparam int WANDER_MIN_MS = 25;
  localparam int WANDER_MAX_MS = 2500;
  localparam int WANDER_MIN_CYC = WANDER_MIN_MS * CLK_KHZ;
  localparam int WANDER_MAX_CYC = WANDER_MAX_MS * CLK_KHZ;
  localparam int WANDER_SETTING_MAX = 255;
  localparam logic [15:0] PITCH_SEED_BASE = 16'hACE1;
  localparam logic [15:0] SETTING_SEED_BASE = 16'h5A3C;
  localparam logic [15:0] SEED_STEP = 16'h03C5;
  // 256/(N-1) per stack size, so the outermost voices sit at +-spread
  function automatic logic [8:0] spread_recip(input logic [3:0] n);
    unique case (n)
      4'h2: spread_recip = 9'h100;
      4'h3: spread_recip = 9'h080;
      4'h4: spread_recip = 9'h055;
      4'h6: spread_recip = 9'h033;
      4'hC: spread_recip = 9'h017;
      default: spread_recip = 9'h000;
    endcase
  endfunction : spread_recip
endpackage : pva_pkg

/* File: pva_voice_allocator.sv */
`timescale 1ns/1ps
module pva_voice_allocator #(
  parameter int WANDER_MIN_CYCLES = pva_pkg::WANDER_MIN_CYC,
  parameter int WANDER_MAX_CYCLES = pva_pkg::WANDER_MAX_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic noteOnValid,
  input wire logic noteOffValid,
  input wire logic [pva_pkg::NOTE_W-1:0] noteNum,
  output logic noteReady,
  input wire logic [3:0] allocMode,
  input wire logic [1:0] notePriority,
  input wire logic [1:0] envelope_start_policy,
  input wire logic [7:0] stacked_voice_spread,
  input wire logic [7:0] pitch_wander_depth,
  input wire logic [7:0] setting_wander_depth,
  input wire logic [7:0] wanderInterval,
  output logic [pva_pkg::NUM_VOICES-1:0] voiceGate,
  output logic [pva_pkg::NUM_VOICES*pva_pkg::NOTE_W-1:0] voiceNote,
  output logic [pva_pkg::NUM_VOICES*9-1:0] voiceDetune,
  output logic [pva_pkg::NUM_VOICES-1:0] voiceAttack,
  output logic [pva_pkg::NUM_VOICES-1:0] voiceEnvZero,
  output logic [pva_pkg::NUM_VOICES-1:0] voiceSkipSustain,
  output logic [pva_pkg::NUM_VOICES*pva_pkg::DRIFT_W-1:0] pitchWander,
  output logic [pva_pkg::NUM_VOICES*pva_pkg::NUM_SETTINGS*pva_pkg::DRIFT_W-1:0] settingWander
);
  import pva_pkg::*;

  localparam int STEP_CYCLES = (WANDER_MAX_CYCLES - WANDER_MIN_CYCLES) / WANDER_SETTING_MAX;

  typedef enum logic {ST_IDLE, ST_ASSIGN} pva_state_t;

  // ****************************************
  // state
  // ****************************************
  pva_state_t state_reg;
  pva_state_t state_next;
  logic ready_reg;
  logic [NUM_VOICES-1:0] active_reg;
  logic [NUM_VOICES-1:0] assigned_reg;
  logic [NUM_VOICES-1:0] attack_reg;
  logic [NUM_VOICES-1:0] zero_reg;
  logic [NUM_VOICES-1:0] skip_reg;
  logic [NOTE_W-1:0] note_reg [NUM_VOICES];
  logic [AGE_W-1:0] age_reg [NUM_VOICES];
  logic signed [8:0] detune_reg [NUM_VOICES];
  logic [3:0] lastSlot_reg;
  logic [3:0] step_reg;
  logic [3:0] mode_reg;
  logic [NOTE_W-1:0] curNote_reg;

  // ****************************************
  // request decode
  // ****************************************
  logic onTake;
  logic offTake;
  assign onTake = (state_reg == ST_IDLE) && noteOnValid;
  assign offTake = (state_reg == ST_IDLE) && !noteOnValid && noteOffValid;

  // ****************************************
  // mode decode
  // ****************************************
  logic [3:0] stackN;
  logic isMono;
  logic [3:0] poolCap;
  always_comb begin
    stackN = 4'h1;
    isMono = 1'b0;
    poolCap = 4'(NUM_VOICES);
    case (mode_reg)
      MODE_POLY: stackN = 4'h1;
      MODE_STACK2: stackN = 4'h2;
      MODE_STACK3: stackN = 4'h3;
      MODE_STACK4: stackN = 4'h4;
      MODE_STACK6: stackN = 4'h6;
      MODE_STACK12: stackN = 4'(NUM_VOICES);
      MODE_MONO: begin
        stackN = 4'h1;
        isMono = 1'b1;
      end
      MODE_MONO2: begin
        stackN = 4'h2;
        isMono = 1'b1;
      end
      MODE_MONO3: begin
        stackN = 4'h3;
        isMono = 1'b1;
      end
      MODE_MONO4: begin
        stackN = 4'h4;
        isMono = 1'b1;
      end
      MODE_MONO6: begin
        stackN = 4'h6;
        isMono = 1'b1;
      end
      MODE_POLY6: poolCap = CAP_POLY6;
      MODE_POLY8: poolCap = CAP_POLY8;
      // unused codes fall back to plain polyphony
      default: stackN = 4'h1;
    endcase
  end

  // the capped modes confine notes to the first slots; simpler than a live count
  logic [NUM_VOICES-1:0] poolMask;
  logic [NUM_VOICES-1:0] freeMask;
  logic [NUM_VOICES-1:0] candMask;
  logic [NUM_VOICES-1:0] soundMask;
  assign poolMask = NUM_VOICES'((13'h1 << poolCap) - 13'h1);
  assign freeMask = poolMask & ~active_reg & ~assigned_reg;
  assign candMask = poolMask & active_reg & ~assigned_reg;
  assign soundMask = poolMask & active_reg;

  // ****************************************
  // slot search
  // ****************************************
  logic freeFound;
  logic [3:0] freeSlot;
  always_comb begin
    int idx;
    idx = 0;
    freeFound = 1'b0;
    freeSlot = 4'h0;
    // walk backwards so the nearest slot after the last one wins
    for (int i = NUM_VOICES; i >= 1; i--) begin
      idx = (int'(lastSlot_reg) + i) % NUM_VOICES;
      if (freeMask[idx]) begin
        freeFound = 1'b1;
        freeSlot = 4'(idx);
      end
    end
  end

  logic candFound;
  logic [3:0] oldSlot;
  logic [3:0] hiSlot;
  logic [3:0] loSlot;
  logic [NOTE_W-1:0] minNote;
  logic [NOTE_W-1:0] maxNote;
  always_comb begin
    logic [AGE_W-1:0] bestAge;
    logic [NOTE_W-1:0] hiNote;
    logic [NOTE_W-1:0] loNote;
    bestAge = '0;
    hiNote = '0;
    loNote = '1;
    candFound = 1'b0;
    oldSlot = 4'h0;
    hiSlot = 4'h0;
    loSlot = 4'h0;
    minNote = '1;
    maxNote = '0;
    for (int i = 0; i < NUM_VOICES; i++) begin
      if (candMask[i]) begin
        if (!candFound || age_reg[i] > bestAge) begin
          bestAge = age_reg[i];
          oldSlot = 4'(i);
        end
        if (!candFound || note_reg[i] > hiNote) begin
          hiNote = note_reg[i];
          hiSlot = 4'(i);
        end
        if (!candFound || note_reg[i] < loNote) begin
          loNote = note_reg[i];
          loSlot = 4'(i);
        end
        candFound = 1'b1;
      end
      if (soundMask[i] && note_reg[i] < minNote) begin
        minNote = note_reg[i];
      end
      if (soundMask[i] && note_reg[i] > maxNote) begin
        maxNote = note_reg[i];
      end
    end
  end

  // ****************************************
  // assignment decision
  // ****************************************
  logic [3:0] target;
  logic doAssign;
  logic monoWins;
  logic stealOk;
  logic [3:0] stealSlot;
  assign monoWins = !active_reg[step_reg]
                    || (notePriority == PRIO_LOWEST && curNote_reg < note_reg[step_reg])
                    || (notePriority == PRIO_HIGHEST && curNote_reg > note_reg[step_reg])
                    || (notePriority != PRIO_LOWEST && notePriority != PRIO_HIGHEST);
  assign stealOk = candFound
                   && ((notePriority == PRIO_LOWEST && curNote_reg < minNote)
                       || (notePriority == PRIO_HIGHEST && curNote_reg > maxNote)
                       || (notePriority != PRIO_LOWEST && notePriority != PRIO_HIGHEST));
  assign stealSlot = (notePriority == PRIO_LOWEST) ? hiSlot :
                     (notePriority == PRIO_HIGHEST) ? loSlot : oldSlot;
  // mono groups always use slots 0..N-1 in order
  assign target = isMono ? step_reg : (freeFound ? freeSlot : stealSlot);
  assign doAssign = (state_reg == ST_ASSIGN) && (isMono ? monoWins : (freeFound || stealOk));

  // ****************************************
  // detune spread
  // ****************************************
  logic signed [8:0] spreadOffset;
  logic signed [5:0] spreadPos;
  logic signed [31:0] spreadProd;
  // position 2k-(N-1) is odd for even N, so no voice lands on the root
  assign spreadPos = 6'(2 * int'(step_reg)) - 6'(int'(stackN) - 1);
  assign spreadProd = $signed({24'h0, stacked_voice_spread}) * 32'(spreadPos)
                      * $signed({23'h0, spread_recip(stackN)});
  assign spreadOffset = 9'(spreadProd >>> 8);

  // ****************************************
  // sequencer
  // ****************************************
  logic lastStep;
  assign lastStep = (step_reg == stackN - 4'h1);
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (onTake) begin
          state_next = ST_ASSIGN;
        end
      end
      ST_ASSIGN: begin
        // a refused step ends the note: the remaining stack is dropped
        if (!doAssign || lastStep) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b1;
      step_reg <= 4'h0;
      mode_reg <= MODE_POLY;
      curNote_reg <= '0;
      lastSlot_reg <= 4'(NUM_VOICES - 1);
      assigned_reg <= '0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ST_IDLE);
      if (onTake) begin
        step_reg <= 4'h0;
        mode_reg <= allocMode;
        curNote_reg <= noteNum;
        assigned_reg <= '0;
      end else if (doAssign) begin
        step_reg <= step_reg + 4'h1;
        lastSlot_reg <= target;
        assigned_reg[target] <= 1'b1;
      end
    end
  end

  // ****************************************
  // per-voice slot state
  // ****************************************
  for (genvar v = 0; v < NUM_VOICES; v++) begin : g_voice
    logic hit;
    logic offHit;
    logic legatoHold;
    assign hit = doAssign && (target == 4'(v));
    assign offHit = offTake && active_reg[v] && (note_reg[v] == noteNum);
    assign legatoHold = (envelope_start_policy == ENV_LEGATO) && active_reg[v];
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        active_reg[v] <= 1'b0;
        note_reg[v] <= '0;
        age_reg[v] <= '0;
        detune_reg[v] <= 9'sh000;
        attack_reg[v] <= 1'b0;
        zero_reg[v] <= 1'b0;
        skip_reg[v] <= 1'b0;
      end else begin
        // an assignment wins over a release in the same cycle
        active_reg[v] <= hit | (active_reg[v] & ~offHit);
        attack_reg[v] <= hit && !legatoHold;
        zero_reg[v] <= hit && (envelope_start_policy == ENV_RETRIGGER
                               || envelope_start_policy == ENV_ONE_SHOT);
        if (hit) begin
          note_reg[v] <= curNote_reg;
          age_reg[v] <= '0;
          detune_reg[v] <= spreadOffset;
          skip_reg[v] <= (envelope_start_policy == ENV_ONE_SHOT);
        end else if (onTake && age_reg[v] != AGE_MAX) begin
          age_reg[v] <= age_reg[v] + 4'h1;
        end
      end
    end
    assign voiceNote[v*NOTE_W +: NOTE_W] = note_reg[v];
    assign voiceDetune[v*9 +: 9] = detune_reg[v];

    // ****************************************
    // wander generators, two per voice
    // ****************************************
    pva_wander_if #(.NOUT(1)) pitchIf();
    pva_wander_if #(.NOUT(NUM_SETTINGS)) settingIf();
    assign pitchIf.depth = pitch_wander_depth;
    assign pitchIf.rate = wanderInterval;
    assign settingIf.depth = setting_wander_depth;
    assign settingIf.rate = wanderInterval;
    pva_wander_gen #(
      .NOUT(1),
      .SEED(PITCH_SEED_BASE + 16'(v) * SEED_STEP),
      .MIN_CYC(WANDER_MIN_CYCLES),
      .STEP_CYC(STEP_CYCLES)
    ) u_pitch (
      .clock(clock),
      .sys_rst(sys_rst),
      .wif(pitchIf)
    );
    pva_wander_gen #(
      .NOUT(NUM_SETTINGS),
      .SEED(SETTING_SEED_BASE + 16'(v) * SEED_STEP),
      .MIN_CYC(WANDER_MIN_CYCLES),
      .STEP_CYC(STEP_CYCLES)
    ) u_setting (
      .clock(clock),
      .sys_rst(sys_rst),
      .wif(settingIf)
    );
    assign pitchWander[v*DRIFT_W +: DRIFT_W] = pitchIf.drift;
    assign settingWander[v*NUM_SETTINGS*DRIFT_W +: NUM_SETTINGS*DRIFT_W] = settingIf.drift;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign noteReady = ready_reg;
  assign voiceGate = active_reg;
  assign voiceAttack = attack_reg;
  assign voiceEnvZero = zero_reg;
  assign voiceSkipSustain = skip_reg;
endmodule : pva_voice_allocator

/* File: pva_voice_allocator_monitor.sv */
`timescale 1ns/1ps
module pva_voice_allocator_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic noteOnValid,
  input wire logic noteReady,
  input wire logic [3:0] allocMode,
  input wire logic [1:0] notePriority,
  input wire logic [7:0] stacked_voice_spread,
  input wire logic [7:0] pitch_wander_depth,
  input wire logic [pva_pkg::NUM_VOICES-1:0] voiceGate,
  input wire logic [pva_pkg::NUM_VOICES*9-1:0] voiceDetune,
  input wire logic [pva_pkg::NUM_VOICES-1:0] voiceAttack,
  input wire logic [pva_pkg::NUM_VOICES-1:0] voiceEnvZero,
  input wire logic [pva_pkg::NUM_VOICES*pva_pkg::DRIFT_W-1:0] pitchWander
);
  import pva_pkg::*;
  // ****
  // note event timing
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence take_on;
    noteReady && noteOnValid;
  endsequence
  // a refused note still spends one busy cycle, so the lower bound is 1
  sequence assign_run;
    !noteReady ##[1:12] noteReady;
  endsequence
  run_length_a: assert property (take_on |=> assign_run)
    else $error("note-on busy span out of range");
  stack_all_a: assert property (noteReady && noteOnValid && allocMode == MODE_STACK12
    && notePriority == PRIO_LAST |-> ##13 voiceGate == 12'hFFF) else $error("stack of twelve not complete");
  mono_slot_a: assert property (noteReady && noteOnValid && allocMode == MODE_MONO
    |=> (voiceAttack[NUM_VOICES-1:1] == 11'h000) [*2]) else $error("mono used another slot");
  one_attack_a: assert property ($onehot0(voiceAttack)) else $error("two slots started at once");
  attack_gate_a: assert property ((voiceAttack & ~voiceGate) == 12'h000)
    else $error("attack on idle slot");
  zero_attack_a: assert property ((voiceEnvZero & ~voiceAttack) == 12'h000)
    else $error("envelope zeroed without attack");
  attack_pulse_a: assert property ((voiceAttack & $past(voiceAttack)) == 12'h000)
    else $error("attack longer than one cycle");
  spread_zero_a: assert property (voiceAttack[0] && $past(stacked_voice_spread) == 8'h00
    |-> voiceDetune[8:0] == 9'h000) else $error("detune with zero spread");
  no_gate_a: assert property (noteReady && !noteOnValid |=> (voiceGate & ~$past(voiceGate)) == 12'h000)
    else $error("gate rose without note-on");
  wander_off_a: assert property ($past(pitch_wander_depth) == 8'h00
    && $past(pitch_wander_depth, 2) == 8'h00 |-> pitchWander == '0) else $error("pitch wander with zero depth");
endmodule : pva_voice_allocator_monitor

/* File: pva_voice_allocator_tb_top.sv */
`timescale 1ns/1ps
module pva_voice_allocator_tb_top;
  import pva_pkg::*;
  typedef struct packed {logic [3:0] mode; logic [3:0] n; logic [8:0] recip; logic [11:0] mask;} pva_row_t;
  localparam pva_row_t ROWS [13] = '{
    '{MODE_POLY, 4'h1, 9'h000, 12'h001}, '{MODE_STACK2, 4'h2, 9'h100, 12'h003},
    '{MODE_STACK3, 4'h3, 9'h080, 12'h007}, '{MODE_STACK4, 4'h4, 9'h055, 12'h00F},
    '{MODE_STACK6, 4'h6, 9'h033, 12'h03F}, '{MODE_STACK12, 4'hC, 9'h017, 12'hFFF},
    '{MODE_MONO, 4'h1, 9'h000, 12'h001}, '{MODE_MONO2, 4'h2, 9'h100, 12'h003},
    '{MODE_MONO3, 4'h3, 9'h080, 12'h007}, '{MODE_MONO4, 4'h4, 9'h055, 12'h00F},
    '{MODE_MONO6, 4'h6, 9'h033, 12'h03F}, '{MODE_POLY6, 4'h1, 9'h000, 12'h001},
    '{MODE_POLY8, 4'h1, 9'h000, 12'h001}};
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic noteOnValid, noteOffValid, noteReady;
  logic [NOTE_W-1:0] noteNum;
  logic [3:0] allocMode = MODE_POLY;
  logic [1:0] notePriority = PRIO_LAST;
  logic [1:0] envelope_start_policy = ENV_FROM_LEVEL;
  logic [7:0] stacked_voice_spread = 8'h00;
  logic [7:0] pitch_wander_depth = 8'h00;
  logic [7:0] setting_wander_depth = 8'h00;
  logic [7:0] wanderInterval = 8'h00;
  logic [NUM_VOICES-1:0] voiceGate, voiceAttack, voiceEnvZero, voiceSkipSustain;
  logic [NUM_VOICES*NOTE_W-1:0] voiceNote;
  logic [NUM_VOICES*9-1:0] voiceDetune;
  logic [NUM_VOICES*DRIFT_W-1:0] pitchWander;
  logic [NUM_VOICES*NUM_SETTINGS*DRIFT_W-1:0] settingWander;
  int err_total = 0;
  int n_compared = 0;
  always #2 clock = ~clock;
  // short wander counts keep intervals at 40..80 cycles for setting 0
  pva_voice_allocator #(.WANDER_MIN_CYCLES(40), .WANDER_MAX_CYCLES(4000)) dut (.clock(clock), .sys_rst(sys_rst),
    .noteOnValid(noteOnValid), .noteOffValid(noteOffValid), .noteNum(noteNum), .noteReady(noteReady),
    .allocMode(allocMode), .notePriority(notePriority), .envelope_start_policy(envelope_start_policy),
    .stacked_voice_spread(stacked_voice_spread), .pitch_wander_depth(pitch_wander_depth),
    .setting_wander_depth(setting_wander_depth), .wanderInterval(wanderInterval), .voiceGate(voiceGate),
    .voiceNote(voiceNote), .voiceDetune(voiceDetune), .voiceAttack(voiceAttack), .voiceEnvZero(voiceEnvZero),
    .voiceSkipSustain(voiceSkipSustain), .pitchWander(pitchWander), .settingWander(settingWander));
  pva_note_source src (.clock(clock), .noteReady(noteReady), .voiceAttack(voiceAttack),
    .voiceEnvZero(voiceEnvZero), .noteOnValid(noteOnValid), .noteOffValid(noteOffValid), .noteNum(noteNum));
  // ****
  // helpers
  // ****
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask : do_reset
  function automatic logic [8:0] exp_det(input int k, input int n, input int r);
    int v;
    v = (255 * (2 * k - (n - 1)) * r) >>> 8;
    return 9'(v);
  endfunction : exp_det
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    end_of_test();
  end
  // ****
  // tests
  // ****
  initial begin
    do_reset();
    check("idle gate", voiceGate, 12'h000);
    check("idle ready", 12'(noteReady), 12'h001);
    check("idle wander", 12'(pitchWander[7:0]), 12'h000);
    $display("test reset done");
    for (int i = 0; i < 13; i++) begin
      do_reset();
      allocMode <= ROWS[i].mode;
      stacked_voice_spread <= 8'hFF;
      src.send(1'b1, 7'h3C, i % 2);
      check("alloc gate", voiceGate, ROWS[i].mask);
      check("alloc note", 12'(voiceNote[6:0]), 12'h03C);
      for (int k = 0; k < int'(ROWS[i].n); k++) begin
        check("detune", 12'(voiceDetune[k*9+:9]), 12'(exp_det(k, ROWS[i].n, ROWS[i].recip)));
      end
    end
    $display("test modes done");
    do_reset();
    allocMode <= MODE_POLY;
    stacked_voice_spread <= 8'h00;
    for (int k = 0; k < 12; k++) src.send(1'b1, 7'(40 + k), 0);
    for (int k = 0; k < 12; k++) check("rr note", 12'(voiceNote[k*7+:7]), 12'(40 + k));
    src.send(1'b1, 7'h46, 0);
    check("steal oldest", 12'(voiceNote[6:0]), 12'h046);
    src.send(1'b0, 7'h46, 0);
    check("off gate", voiceGate, 12'hFFE);
    $display("test poly done");
    do_reset();
    allocMode <= MODE_POLY6;
    notePriority <= PRIO_LOWEST;
    for (int k = 0; k < 6; k++) src.send(1'b1, 7'(50 + k), 0);
    src.send(1'b1, 7'h28, 0);
    check("cap gate", voiceGate, 12'h03F);
    check("lowest steal", 12'(voiceNote[41:35]), 12'h028);
    src.send(1'b1, 7'h50, 0);
    check("lowest refuse", 12'(voiceNote[41:35]), 12'h028);
    notePriority <= PRIO_HIGHEST;
    src.send(1'b1, 7'h5A, 0);
    check("highest steal", 12'(voiceNote[41:35]), 12'h05A);
    notePriority <= PRIO_LAST;
    $display("test priority done");
    do_reset();
    allocMode <= MODE_MONO;
    for (int p = 0; p < 4; p++) begin
      envelope_start_policy <= 2'(p);
      src.send(1'b1, 7'(60 + p), 0);
      check("mono gate", voiceGate, 12'h001);
      check("env zero", 12'(src.zeroSeen[0]), 12'(p == 1 || p == 3));
      check("attack", 12'(src.attSeen[0]), 12'(p != 2));
      check("skip sustain", 12'(voiceSkipSustain[0]), 12'(p == 3));
    end
    envelope_start_policy <= ENV_LEGATO;
    src.send(1'b0, 7'h3F, 0);
    src.send(1'b1, 7'h40, 1);
    check("legato after off", 12'(src.attSeen[0]), 12'h001);
    notePriority <= PRIO_LOWEST;
    src.send(1'b1, 7'h46, 0);
    check("mono lowest", 12'(voiceNote[6:0]), 12'h040);
    notePriority <= PRIO_LAST;
    $display("test envelope done");
    pitch_wander_depth <= 8'hFF;
    setting_wander_depth <= 8'hFF;
    wanderInterval <= 8'hFF;
    do_reset();
    repeat (400) @(posedge clock);
    check("slow wander", 12'(pitchWander[7:0]), 12'h000);
    wanderInterval <= 8'h00;
    do_reset();
    repeat (400) @(posedge clock);
    check("pitch moved", 12'(pitchWander[7:0] != 8'h00), 12'h001);
    check("voices differ", 12'(pitchWander[7:0] !== pitchWander[15:8]), 12'h001);
    check("setting moved", 12'(settingWander[7:0] != 8'h00), 12'h001);
    check("source hang", 12'(src.hung), 12'h000);
    $display("test wander done");
    end_of_test();
  end
endmodule : pva_voice_allocator_tb_top
bind pva_voice_allocator pva_voice_allocator_monitor mon (.clock(clock), .sys_rst(sys_rst),
  .noteOnValid(noteOnValid), .noteReady(noteReady), .allocMode(allocMode), .notePriority(notePriority),
  .stacked_voice_spread(stacked_voice_spread), .pitch_wander_depth(pitch_wander_depth), .voiceGate(voiceGate),
  .voiceDetune(voiceDetune), .voiceAttack(voiceAttack), .voiceEnvZero(voiceEnvZero), .pitchWander(pitchWander));

/* File: pva_wander_gen.sv */
`timescale 1ns/1ps
module pva_wander_gen #(
  parameter int NOUT = 1,
  parameter logic [15:0] SEED = 16'h0001,
  parameter int MIN_CYC = pva_pkg::WANDER_MIN_CYC,
  parameter int STEP_CYC = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  pva_wander_if.gen wif
);
  import pva_pkg::*;

  logic [15:0] lfsr_reg;
  logic [15:0] lfsr_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [39:0] baseCyc;
  logic [47:0] spanCyc;
  logic tick;
  logic armed_reg;

  // free-running lfsr; a distinct seed per instance keeps voices independent
  assign lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  assign tick = (cnt_reg == 32'h0);
  assign baseCyc = 40'(MIN_CYC) + 40'(wif.rate) * 40'(STEP_CYC);
  assign spanCyc = 48'(baseCyc) + ((48'(baseCyc) * 48'(lfsr_reg[7:0])) >> 8);
  assign cnt_next = tick ? spanCyc[31:0] : cnt_reg - 32'h1;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr_reg <= SEED;
      cnt_reg <= 32'h0;
      armed_reg <= 1'b0;
    end else begin
      lfsr_reg <= lfsr_next;
      cnt_reg <= cnt_next;
      armed_reg <= 1'b1;
    end
  end

  for (genvar k = 0; k < NOUT; k++) begin : g_out
    logic signed [7:0] cur_reg;
    logic signed [7:0] drift_reg;
    logic signed [7:0] target;
    logic signed [8:0] gap;
    logic signed [7:0] cur_next;
    logic signed [16:0] scaled;
    assign target = $signed(lfsr_reg[(k % 9) +: 8]);
    assign gap = 9'(target) - 9'(cur_reg);
    // halfway step: slow glide, never overshoots the target
    // the tick right after reset only loads the timer, so no move precedes a full interval
    assign cur_next = (tick && armed_reg) ? 8'(9'(cur_reg) + (gap >>> 1)) : cur_reg;
    assign scaled = cur_reg * $signed({1'b0, wif.depth});
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        cur_reg <= 8'sh00;
        drift_reg <= 8'sh00;
      end else begin
        cur_reg <= cur_next;
        drift_reg <= scaled[15:8];
      end
    end
    assign wif.drift[k*8 +: 8] = drift_reg;
  end
endmodule : pva_wander_gen

/* File: pva_wander_if.sv */
`timescale 1ns/1ps
interface pva_wander_if #(parameter int NOUT = 1);
  logic [7:0] depth;
  logic [7:0] rate;
  logic [NOUT*8-1:0] drift;
  modport gen (input depth, input rate, output drift);
  modport host (output depth, output rate, input drift);
endinterface : pva_wander_if
